// File: dv/adc_cmp_model.sv
// Comparator model with a fixed analog level on each of the four inputs.
`timescale 1ns/10ps
module adc_cmp_model (
  input  wire logic [7:0] dac_code,
  input  wire logic [1:0] channel_sel,
  output logic            comp_in
);
  // Input n sits at {n, 6'h15}, so each result shows which input was taken.
  // distinct input levels
  assign comp_in = {channel_sel, 6'h15} >= dac_code;
endmodule

// File: dv/adc_seq_chk.sv
// Port-level assertions for the ADC sequencing control block.
`timescale 1ns/10ps
module adc_seq_chk #(
  parameter int DATA_W = 8
) (
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic [7:0]        sfr_addr,
  input wire logic [DATA_W-1:0] sfr_wdata,
  input wire logic              sfr_wr,
  input wire logic              sfr_rd,
  input wire logic [7:0]        bit_addr,
  input wire logic              bit_wr,
  input wire logic              bit_wval,
  input wire logic [DATA_W-1:0] sfr_rdata,
  input wire logic [1:0]        channel_sel,
  input wire logic              sample_on,
  input wire logic              conversion_done_flag,
  input wire logic              conversion_in_progress,
  input wire logic              start_strobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic trig;
  logic ctl_wr;
  logic clr_done;
  assign trig = sfr_wr && sfr_addr == adc_pkg::ADDR_CONVERSION_TRIGGER;
  assign ctl_wr = sfr_wr && sfr_addr == adc_pkg::ADDR_ADC_CONTROL;
  assign clr_done = (ctl_wr && !sfr_wdata[5]) || (bit_wr && bit_addr == 8'hDD && !bit_wval);
  sequence s_start;
    start_strobe && conversion_in_progress && sample_on;
  endsequence
  sequence s_finish;
    $fell(conversion_in_progress) && conversion_done_flag;
  endsequence
  a_trig_starts: assert property (trig |=> s_start) else $error("no start");
  a_strobe_cause: assert property (start_strobe |-> $past(trig)) else $error("stray");
  a_idle_stays: assert property (!conversion_in_progress && !trig |=>
    !conversion_in_progress) else $error("busy without start");
  a_done_sticky: assert property (conversion_done_flag && !clr_done |=>
    conversion_done_flag) else $error("done lost");
  a_end_together: assert property ($fell(conversion_in_progress) |-> s_finish)
    else $error("end without done");
  a_sample_bound: assert property ($rose(sample_on) |-> ##[1:64] !sample_on)
    else $error("sample too long");
  a_chan_write: assert property (ctl_wr |=> channel_sel == $past(sfr_wdata[1:0]))
    else $error("channel");
  a_rdata_quiet: assert property (!sfr_rd || sfr_addr == adc_pkg::ADDR_CONVERSION_TRIGGER
    |=> sfr_rdata == 8'h00) else $error("rdata");
endmodule
bind adc_seq adc_seq_chk #(.DATA_W(DATA_W)) adc_seq_chk_inst (.clk, .rst_b, .sfr_addr,
  .sfr_wdata, .sfr_wr, .sfr_rd, .bit_addr, .bit_wr, .bit_wval, .sfr_rdata, .channel_sel,
  .sample_on, .conversion_done_flag, .conversion_in_progress, .start_strobe);

// File: dv/tb_top.sv
// Self-checking bench for the ADC sequencing control block.
`timescale 1ns/10ps
module tb_top;
  logic clk = 0, rst_b = 0, sfr_wr = 0, sfr_rd = 0, bit_wr = 0, bit_wval = 0, comp_in;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, bit_addr = 0, sfr_rdata, dac_code;
  logic bit_rdata, int_clk_en, mcycle_pulse, adc_tick, sample_on, start_strobe, prev_sample;
  logic conversion_done_flag, conversion_in_progress;
  logic [1:0] channel_sel;
  int bad_count = 0, compares = 0, cyc = 0, s0, s1, t, e, r;
  adc_seq adc_seq_inst (.clk, .rst_b, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .bit_addr,
    .bit_wr, .bit_wval, .comp_in, .sfr_rdata, .bit_rdata, .int_clk_en, .mcycle_pulse,
    .adc_tick, .channel_sel, .sample_on, .dac_code, .conversion_done_flag,
    .conversion_in_progress, .start_strobe);
  adc_cmp_model adc_cmp_model_inst (.dac_code, .channel_sel, .comp_in);
  always #20 clk = ~clk;
  task automatic test_done;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // A hung wait ends the run as a failure instead of stalling it.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      test_done;
    end
  end
  task automatic chk(string n, logic [7:0] x, logic [7:0] g);
    compares++;
    if (g !== x) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1;
    @(negedge clk);
    sfr_wr = 0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] x, string n);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1;
    @(negedge clk);
    sfr_rd = 0;
    chk(n, x, sfr_rdata);
  endtask
  task automatic bw(logic [7:0] a, logic v);
    @(negedge clk);
    bit_addr = a;
    bit_wval = v;
    bit_wr = 1;
    @(negedge clk);
    bit_wr = 0;
  endtask
  task automatic conv(output int s);
    int n = 0;
    s = 0;
    wr(8'hDA, 8'h00);
    do begin
      s += sample_on;
      @(negedge clk);
      n++;
    end while (conversion_in_progress !== 1'b0 && n < 400);
  endtask
  task automatic ticks;
    t = 0;
    e = 0;
    repeat (40) begin
      @(negedge clk);
      t += adc_tick;
      e += int_clk_en;
    end
  endtask
  task automatic mper(output int p);
    int n = 0;
    while (mcycle_pulse !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    p = 0;
    do begin
      @(negedge clk);
      p++;
    end while (mcycle_pulse !== 1'b1 && p < 50);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst_b = 1;
    rd(8'hD8, 8'h00, "control reset");
    rd(8'hDA, 8'h00, "trigger read");
    chk("no strobe", 0, start_strobe);
    for (int c = 0; c < 4; c++) begin
      wr(8'hD8, 8'(c));
      chk("channel", 8'(c), channel_sel);
      conv(s1);
      if (c == 0) s0 = s1;
      rd(8'hD9, {c[1:0], 6'h15}, "result");
      chk("done flag", 1, conversion_done_flag);
      rd(8'hD8, 8'h20 | 8'(c), "done set busy off");
      bw(8'hDD, 0);
      rd(8'hD8, 8'(c), "done cleared");
      chk("done flag cleared", 0, conversion_done_flag);
    end
    $display("test single conversions done");
    bw(8'hD8, 0);
    bw(8'hD9, 1);
    chk("bit channel", 8'h02, channel_sel);
    @(negedge clk);
    chk("bit read", 1, bit_rdata);
    wr(8'hD8, 8'h10);
    rd(8'hD8, 8'h00, "busy write ignored");
    wr(8'hD9, 8'h3C);
    rd(8'hD9, 8'h3C, "result rw");
    wr(8'hD8, 8'h40);
    conv(s1);
    chk("long sample", 8'(4 * s0), 8'(s1));
    $display("test bits and sample done");
    wr(8'hD8, 8'h00);
    ticks;
    chk("master ticks", 40, 8'(t));
    wr(8'hD8, 8'h80);
    ticks;
    chk("halved ticks", 20, 8'(t));
    wr(8'hD8, 8'h00);
    wr(8'hA6, 8'h80);
    rd(8'hA6, 8'h80, "advanced function");
    ticks;
    chk("core clock", 20, 8'(e));
    mper(r);
    mper(r);
    chk("slow machine cycle", 12, 8'(r));
    wr(8'hA6, 8'h00);
    mper(r);
    mper(r);
    chk("fast machine cycle", 6, 8'(r));
    $display("test clocks done");
    wr(8'hD8, 8'h08);
    wr(8'hDA, 8'h00);
    r = 0;
    prev_sample = sample_on;
    repeat (80) begin
      @(negedge clk);
      r += (sample_on === 1'b1 && prev_sample === 1'b0);
      prev_sample = sample_on;
    end
    chk("restarts", 1, 8'(r >= 2));
    chk("busy continuous", 1, conversion_in_progress);
    wr(8'hD8, 8'h20);
    conv(s1);
    chk("single stops", 0, conversion_in_progress);
    $display("test continuous done");
    test_done;
  end
endmodule

// File: logic/adc_halver.sv
// Enable divider: passes every tick when bypassed, every second tick otherwise.
`timescale 1ns/10ps
module adc_halver (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic tick_in,
  input  wire logic halve,
  output logic      tick_out
);
  logic phase;
  logic next_phase;

  always_comb begin
    next_phase = phase;
    if (!halve) begin
      next_phase = 1'b0;
    end else if (tick_in) begin
      next_phase = ~phase;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      phase <= 1'b0;
    end else begin
      phase <= next_phase;
    end
  end

  assign tick_out = tick_in & (~halve | phase);
endmodule

// File: logic/adc_mcycle.sv
// Machine cycle timer: one pulse every 12 or 6 oscillator cycles.
`timescale 1ns/10ps
module adc_mcycle (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic slow,
  output logic      mcycle_pulse
);
  logic [3:0] count;
  logic [3:0] next_count;
  logic [3:0] last;

  always_comb begin
    last = slow ? 4'(adc_pkg::MACHINE_CYCLE_SLOW - 1) : 4'(adc_pkg::MACHINE_CYCLE_FAST - 1);
    next_count = (count >= last) ? 4'h0 : count + 4'h1;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count        <= 4'h0;
      mcycle_pulse <= 1'b0;
    end else begin
      count        <= next_count;
      mcycle_pulse <= (count >= last);
    end
  end
endmodule

// File: logic/adc_pkg.sv
// Package with register map, field positions, reset values and timing for the ADC sequencer.
package adc_pkg;
  localparam logic [7:0] ADDR_ADVANCED_FUNCTION   = 8'hA6;
  localparam logic [7:0] ADDR_ADC_CONTROL         = 8'hD8;
  localparam logic [7:0] ADDR_ADC_RESULT          = 8'hD9;
  localparam logic [7:0] ADDR_CONVERSION_TRIGGER  = 8'hDA;
  // Bit addresses of the adc_control register (bit-addressable at its base).
  localparam logic [7:0] BIT_BASE_ADC_CONTROL     = 8'hD8;

  localparam int BIT_CHANNEL_SELECT_LOW      = 0;
  localparam int BIT_CHANNEL_SELECT_HIGH     = 1;
  localparam int BIT_MUST_BE_ZERO            = 2;
  localparam int BIT_REPEAT_CONVERSION       = 3;
  localparam int BIT_CONVERSION_IN_PROGRESS  = 4;
  localparam int BIT_CONVERSION_DONE         = 5;
  localparam int BIT_LONG_SAMPLE_SELECT      = 6;
  localparam int BIT_ADC_CLOCK_HALVER        = 7;
  localparam int BIT_CORE_CLOCK_DIVIDER      = 7;

  localparam logic [7:0] RESET_ADC_CONTROL        = 8'h00;
  localparam logic       RESET_CORE_CLOCK_DIVIDER = 1'h0;
  localparam logic [7:0] RESET_ADC_RESULT         = 8'h00;

  // Sample phase in ADC master clock cycles: normal and fourfold.
  localparam int SAMPLE_CYCLES_NORMAL = 2;
  localparam int SAMPLE_CYCLES_LONG   = 8;
  // One successive-approximation step per result bit.
  localparam int RESULT_BITS          = 8;
  // Machine cycle length in oscillator cycles.
  localparam int MACHINE_CYCLE_SLOW   = 12;
  localparam int MACHINE_CYCLE_FAST   = 6;

  typedef enum logic [1:0] {
    ADC_IDLE   = 2'b00,
    ADC_SAMPLE = 2'b01,
    ADC_CONV   = 2'b10
  } adc_state_e;
endpackage

// File: logic/adc_seq.sv
// ADC sequencing control: SFR registers, clock dividers and conversion state machine.
`timescale 1ns/10ps
module adc_seq #(
  parameter int DATA_W = 8
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic [7:0]        sfr_addr,
  input  wire logic [DATA_W-1:0] sfr_wdata,
  input  wire logic              sfr_wr,
  input  wire logic              sfr_rd,
  input  wire logic [7:0]        bit_addr,
  input  wire logic              bit_wr,
  input  wire logic              bit_wval,
  input  wire logic              comp_in,
  output logic [DATA_W-1:0]      sfr_rdata,
  output logic                   bit_rdata,
  output logic                   int_clk_en,
  output logic                   mcycle_pulse,
  output logic                   adc_tick,
  output logic [1:0]             channel_sel,
  output logic                   sample_on,
  output logic [DATA_W-1:0]      dac_code,
  output logic                   conversion_done_flag,
  output logic                   conversion_in_progress,
  output logic                   start_strobe
);
  logic [7:0]              adc_control;
  logic [7:0]              next_adc_control;
  logic                    core_clock_divider;
  logic                    next_core_clock_divider;
  logic [DATA_W-1:0]       adc_result;
  logic [DATA_W-1:0]       next_adc_result;
  logic [DATA_W-1:0]       sar;
  logic [DATA_W-1:0]       next_sar;
  logic [DATA_W-1:0]       trial;
  logic [DATA_W-1:0]       next_trial;
  logic [3:0]              sample_cnt;
  logic [3:0]              next_sample_cnt;
  adc_pkg::adc_state_e     state;
  adc_pkg::adc_state_e     next_state;
  logic                    osc_half;
  logic                    next_osc_half;
  logic                    chip_tick;
  logic                    master_tick;
  logic                    mcyc;
  logic                    start_req;
  logic                    done_now;
  logic                    next_start_strobe;
  logic [DATA_W-1:0]       next_rdata;
  logic                    next_bit_rdata;
  logic [3:0]              sample_len;
  logic                    sample_last;
  logic [DATA_W-1:0]       conv_value;
  logic                    ctl_byte_wr;
  logic                    ctl_bit_hit;
  logic                    result_byte_wr;
  logic                    afr_byte_wr;
  logic                    next_int_clk_en;
  logic                    next_mcycle_pulse;
  logic                    next_adc_tick;
  logic [1:0]              next_channel_sel;
  logic                    next_sample_on;
  logic [DATA_W-1:0]       next_dac_code;

  // There is one clock; each slower rate is a one-cycle enable, so no derived
  // clock edge ever reaches a flip-flop.
  // internal clock halving
  always_comb begin
    next_osc_half = core_clock_divider ? ~osc_half : 1'b0;
    chip_tick     = ~core_clock_divider | osc_half;
  end

  adc_halver u_halver (
    .clk      (clk),
    .rst_b    (rst_b),
    .tick_in  (chip_tick),
    .halve    (adc_control[adc_pkg::BIT_ADC_CLOCK_HALVER]),
    .tick_out (master_tick)
  );

  adc_mcycle u_mcycle (
    .clk          (clk),
    .rst_b        (rst_b),
    .slow         (core_clock_divider),
    .mcycle_pulse (mcyc)
  );

  // The written value is never looked at, so any byte written here starts.
  // address-only start decode
  assign start_req = sfr_wr && (sfr_addr == adc_pkg::ADDR_CONVERSION_TRIGGER);

  // Write decodes shared by the register updates below.
  assign ctl_byte_wr    = sfr_wr && (sfr_addr == adc_pkg::ADDR_ADC_CONTROL);
  assign result_byte_wr = sfr_wr && (sfr_addr == adc_pkg::ADDR_ADC_RESULT);
  assign afr_byte_wr    = sfr_wr && (sfr_addr == adc_pkg::ADDR_ADVANCED_FUNCTION);
  assign ctl_bit_hit    = (bit_addr[7:3] == adc_pkg::BIT_BASE_ADC_CONTROL[7:3]);

  assign sample_len = adc_control[adc_pkg::BIT_LONG_SAMPLE_SELECT]
                    ? 4'(adc_pkg::SAMPLE_CYCLES_LONG) : 4'(adc_pkg::SAMPLE_CYCLES_NORMAL);
  // Sampling ends on the master tick that completes the selected length.
  assign sample_last = (sample_cnt == sample_len - 4'h1);

  // Word as it stands once the comparator has judged the current trial bit.
  assign conv_value  = comp_in ? (sar | trial) : sar;

  always_comb begin
    next_state      = state;
    next_sample_cnt = sample_cnt;
    next_sar        = sar;
    next_trial      = trial;
    done_now        = 1'b0;
    if (start_req) begin
      // A write to the trigger restarts a conversion in progress.
      next_state      = adc_pkg::ADC_SAMPLE;
      next_sample_cnt = 4'h0;
    end else if (master_tick) begin
      unique case (state)
        adc_pkg::ADC_IDLE: begin
          next_state = adc_pkg::ADC_IDLE;
        end
        adc_pkg::ADC_SAMPLE: begin
          if (sample_last) begin
            next_state = adc_pkg::ADC_CONV;
            next_sar   = '0;
            next_trial = {1'b1, {(DATA_W-1){1'b0}}};
          end else begin
            next_sample_cnt = sample_cnt + 4'h1;
          end
        end
        adc_pkg::ADC_CONV: begin
          // Comparator high means the input is at or above the trial code.
          if (comp_in) begin
            next_sar = sar | trial;
          end
          next_trial = trial >> 1;
          if (trial[0]) begin
            done_now = 1'b1;
            if (adc_control[adc_pkg::BIT_REPEAT_CONVERSION]) begin
              next_state      = adc_pkg::ADC_SAMPLE;
              next_sample_cnt = 4'h0;
            end else begin
              next_state = adc_pkg::ADC_IDLE;
            end
          end
        end
        default: begin
          next_state = adc_pkg::ADC_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    next_adc_control        = adc_control;
    next_core_clock_divider = core_clock_divider;
    next_adc_result         = adc_result;
    if (ctl_byte_wr) begin
      next_adc_control = sfr_wdata[7:0];
    end
    if (bit_wr && ctl_bit_hit) begin
      next_adc_control[bit_addr[2:0]] = bit_wval;
    end
    // bit 2 is held at zero
    next_adc_control[adc_pkg::BIT_MUST_BE_ZERO] = 1'b0;
    // Busy comes from the next state, so it can never disagree with the sequencer.
    // busy follows hardware only
    next_adc_control[adc_pkg::BIT_CONVERSION_IN_PROGRESS] = (next_state != adc_pkg::ADC_IDLE);
    // A clear in the completion cycle loses, so no finished conversion goes unseen.
    // done set wins over software clear
    if (done_now) begin
      next_adc_control[adc_pkg::BIT_CONVERSION_DONE] = 1'b1;
    end
    // Only the divider bit is stored; the reserved and watchdog bits are not.
    // reserved bits ignored
    if (afr_byte_wr) begin
      next_core_clock_divider = sfr_wdata[adc_pkg::BIT_CORE_CLOCK_DIVIDER];
    end
    // A completion in the cycle of a software write keeps the converted value.
    // result load and software write
    if (done_now) begin
      next_adc_result = conv_value;
    end else if (result_byte_wr) begin
      next_adc_result = sfr_wdata;
    end
  end

  always_comb begin
    next_rdata = '0;
    if (sfr_rd) begin
      unique case (sfr_addr)
        adc_pkg::ADDR_ADC_CONTROL:       next_rdata = adc_control;
        adc_pkg::ADDR_ADC_RESULT:        next_rdata = adc_result;
        adc_pkg::ADDR_ADVANCED_FUNCTION: next_rdata = {core_clock_divider, 7'h00};
        default:                         next_rdata = '0;
      endcase
    end
  end

  // Next values of the registered output ports.
  always_comb begin
    next_bit_rdata    = ctl_bit_hit ? adc_control[bit_addr[2:0]] : 1'b0;
    next_start_strobe = start_req;
    next_int_clk_en   = chip_tick;
    next_mcycle_pulse = mcyc;
    next_adc_tick     = master_tick;
    next_channel_sel  = next_adc_control[adc_pkg::BIT_CHANNEL_SELECT_HIGH:
                                         adc_pkg::BIT_CHANNEL_SELECT_LOW];
    next_sample_on    = (next_state == adc_pkg::ADC_SAMPLE);
    // The code shown is the trial that the sequencer weighs on its next tick.
    next_dac_code     = next_sar | next_trial;
  end

  // Sequencer state; a reset mid-conversion returns it to idle with no stale step.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state      <= adc_pkg::ADC_IDLE;
      sample_cnt <= 4'h0;
      sar        <= '0;
      trial      <= '0;
    end else begin
      state      <= next_state;
      sample_cnt <= next_sample_cnt;
      sar        <= next_sar;
      trial      <= next_trial;
    end
  end

  // Register file and the internal clock divider.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      // The result has no defined reset value; zero keeps it free of unknowns.
      adc_control        <= adc_pkg::RESET_ADC_CONTROL;
      core_clock_divider <= adc_pkg::RESET_CORE_CLOCK_DIVIDER;
      adc_result         <= adc_pkg::RESET_ADC_RESULT;
      osc_half           <= 1'b0;
    end else begin
      adc_control        <= next_adc_control;
      core_clock_divider <= next_core_clock_divider;
      adc_result         <= next_adc_result;
      osc_half           <= next_osc_half;
    end
  end

  // Every port leaves straight from a flip-flop, so no decode glitch escapes.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sfr_rdata    <= '0;
      bit_rdata    <= 1'b0;
      start_strobe <= 1'b0;
      int_clk_en   <= 1'b0;
      mcycle_pulse <= 1'b0;
      adc_tick     <= 1'b0;
      channel_sel  <= 2'h0;
      sample_on    <= 1'b0;
      dac_code     <= '0;
    end else begin
      sfr_rdata    <= next_rdata;
      bit_rdata    <= next_bit_rdata;
      start_strobe <= next_start_strobe;
      int_clk_en   <= next_int_clk_en;
      mcycle_pulse <= next_mcycle_pulse;
      adc_tick     <= next_adc_tick;
      channel_sel  <= next_channel_sel;
      sample_on    <= next_sample_on;
      dac_code     <= next_dac_code;
    end
  end

  // The flags are bits of the control register, so port and register never differ.
  assign conversion_done_flag   = adc_control[adc_pkg::BIT_CONVERSION_DONE];
  assign conversion_in_progress = adc_control[adc_pkg::BIT_CONVERSION_IN_PROGRESS];
endmodule
